// ==== verilog/ocp_pkg.sv ====
// ocp_pkg: register map, field positions, reset values and timing counts
// for the overcurrent protection state machine.
// assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
package ocp_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and delay timing
	localparam int OCP_CLK_MHZ = 200;
	// nominal detect and release delay at the smallest recommended timing cap
	localparam int OCP_DELAY_MS = 10;
	localparam int OCP_DELAY_CYCLES = OCP_DELAY_MS * 1000 * OCP_CLK_MHZ;
	localparam int OCP_CNT_W = 24;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OCP_ADDR_CTRL = 8'h00;
	localparam logic [7:0] OCP_ADDR_CONFIG = 8'h04;
	localparam logic [7:0] OCP_ADDR_DELAY = 8'h08;
	localparam logic [7:0] OCP_ADDR_STATUS = 8'h0C;
	localparam logic [7:0] OCP_ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] OCP_ADDR_IRQ_CLR = 8'h14;
	localparam logic [7:0] OCP_ADDR_IRQ_EN = 8'h18;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int OCP_CTRL_DSG_BIT = 0;
	localparam int OCP_CTRL_CHG_BIT = 1;
	localparam int OCP_CFG_THR_LO_BIT = 0;
	localparam int OCP_CFG_THR_HI_BIT = 1;
	localparam int OCP_NUM_THR = 4;
	localparam int OCP_NUM_EVT = 4;
	localparam int OCP_EVT_DETECT_START = 0;
	localparam int OCP_EVT_DETECT_CANCEL = 1;
	localparam int OCP_EVT_PROT_ENTER = 2;
	localparam int OCP_EVT_PROT_EXIT = 3;
	localparam int OCP_STAT_W = 7;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [1:0] OCP_CTRL_RST = 2'h0;
	localparam logic [1:0] OCP_CFG_RST = 2'h0;
	localparam logic [OCP_NUM_EVT-1:0] OCP_IRQ_EN_RST = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// bus responses
	localparam logic [1:0] OCP_RESP_OKAY = 2'h0;
	localparam logic [1:0] OCP_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OCP_ST_NORMAL,
		OCP_ST_DETECT,
		OCP_ST_LOAD_MON,
		OCP_ST_RELEASE
	} ocp_state_t;

endpackage

// ==== verilog/ocp_sync.sv ====
// ocp_sync: two-flop synchroniser for a group of independent pin levels.
// assumes each bit is a slow level; multi-bit groups are not coherent.
`timescale 1ns/100ps

module ocp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// the first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// ==== verilog/ocp_protect.sv ====
// ocp_protect: overcurrent protection state machine with AXI4-Lite registers.
// assumes comparator and load-sense results arrive asynchronously from the
// analog front end; gate outputs drive external FET drivers (high = FET off).
`timescale 1ns/100ps

module ocp_protect
	import ocp_pkg::*;
#(
	parameter logic [OCP_CNT_W-1:0] DELAY_DEFAULT = OCP_CNT_W'(OCP_DELAY_CYCLES)
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic [OCP_NUM_THR-1:0] sense_diff_above,
	input wire logic load_above_release,
	output logic discharge_gate_out,
	output logic charge_gate_load_sense,
	output logic load_test_current,
	output logic regulator_en,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [OCP_NUM_THR:0] pins_s;

	ocp_sync #(
		.WIDTH(OCP_NUM_THR + 1)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.async_in({load_above_release, sense_diff_above}),
		.sync_out(pins_s)
	);

	////////////////////////////////////////////////////////////////////////
	// registers and state
	logic discharge_switch_ctl_r;
	logic charge_switch_ctl_r;
	logic oc_threshold_sel_hi_r;
	logic oc_threshold_sel_lo_r;
	logic [OCP_CNT_W-1:0] oc_delay_r;
	logic [OCP_NUM_EVT-1:0] irq_stat_r;
	logic [OCP_NUM_EVT-1:0] irq_en_r;
	ocp_state_t state_r;
	ocp_state_t state_nxt;
	logic [OCP_CNT_W-1:0] cnt_r;
	logic dsg_at_entry_r;
	logic aw_got_r;
	logic w_got_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;

	////////////////////////////////////////////////////////////////////////
	// comparator selection and state decode
	wire [1:0] thr_sel = {oc_threshold_sel_hi_r, oc_threshold_sel_lo_r};
	wire over_thr = pins_s[thr_sel];
	wire load_high = pins_s[OCP_NUM_THR];
	wire in_prot = (state_r == OCP_ST_LOAD_MON) || (state_r == OCP_ST_RELEASE);
	// a delay of zero would wrap the compare limit to all ones, so it is treated as one cycle
	wire [OCP_CNT_W-1:0] delay_eff = (oc_delay_r == '0) ? OCP_CNT_W'(1) : oc_delay_r;
	wire cnt_done = (cnt_r >= delay_eff - OCP_CNT_W'(1));

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			OCP_ST_NORMAL: begin
				if (over_thr)
					state_nxt = OCP_ST_DETECT;
			end
			OCP_ST_DETECT: begin
				if (!over_thr)
					state_nxt = OCP_ST_NORMAL;
				else if (cnt_done)
					state_nxt = OCP_ST_LOAD_MON;
			end
			OCP_ST_LOAD_MON: begin
				if (load_high)
					state_nxt = OCP_ST_RELEASE;
			end
			OCP_ST_RELEASE: begin
				// load dropped again: keep monitoring
				if (!load_high)
					state_nxt = OCP_ST_LOAD_MON;
				else if (cnt_done && !over_thr)
					state_nxt = OCP_ST_NORMAL;
				else if (cnt_done)
					state_nxt = OCP_ST_LOAD_MON;
			end
			default: state_nxt = OCP_ST_NORMAL;
		endcase
	end

	wire entering = (state_r == OCP_ST_DETECT) && (state_nxt == OCP_ST_LOAD_MON);
	wire exiting = (state_r == OCP_ST_RELEASE) && (state_nxt == OCP_ST_NORMAL);
	wire cnt_clear = (state_nxt != state_r);

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= OCP_ST_NORMAL;
			cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_clear ? '0 : (cnt_r + OCP_CNT_W'(1));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus write path: address and data taken in either order
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire [7:0] wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr;
	wire [31:0] wr_data = w_got_r ? wdata_r : s_axi_wdata;
	wire [3:0] wr_strb = w_got_r ? wstrb_r : s_axi_wstrb;
	wire wr_fire = (aw_got_r || aw_take) && (w_got_r || w_take);
	wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire wr_ctrl = wr_fire && (wr_addr == OCP_ADDR_CTRL) && wr_strb[0];
	wire wr_cfg = wr_fire && (wr_addr == OCP_ADDR_CONFIG) && wr_strb[0];
	wire wr_delay = wr_fire && (wr_addr == OCP_ADDR_DELAY);
	wire wr_clr = wr_fire && (wr_addr == OCP_ADDR_IRQ_CLR) && wr_strb[0];
	wire wr_en = wr_fire && (wr_addr == OCP_ADDR_IRQ_EN) && wr_strb[0];
	wire wr_known = (wr_addr == OCP_ADDR_CTRL) || (wr_addr == OCP_ADDR_CONFIG) ||
		(wr_addr == OCP_ADDR_DELAY) || (wr_addr == OCP_ADDR_IRQ_CLR) ||
		(wr_addr == OCP_ADDR_IRQ_EN);
	wire [31:0] delay_merge = ({8'h00, oc_delay_r} & ~wr_mask) | (wr_data & wr_mask);

	assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
	assign s_axi_wready = !w_got_r && !s_axi_bvalid;

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= OCP_RESP_OKAY;
		end else begin
			if (wr_fire) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? OCP_RESP_OKAY : OCP_RESP_SLVERR;
			end else begin
				if (aw_take) begin
					aw_got_r <= 1'b1;
					awaddr_r <= s_axi_awaddr;
				end
				if (w_take) begin
					w_got_r <= 1'b1;
					wdata_r <= s_axi_wdata;
					wstrb_r <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge clk) begin
		if (reset) begin
			discharge_switch_ctl_r <= OCP_CTRL_RST[OCP_CTRL_DSG_BIT];
			charge_switch_ctl_r <= OCP_CTRL_RST[OCP_CTRL_CHG_BIT];
			oc_threshold_sel_lo_r <= OCP_CFG_RST[OCP_CFG_THR_LO_BIT];
			oc_threshold_sel_hi_r <= OCP_CFG_RST[OCP_CFG_THR_HI_BIT];
			oc_delay_r <= DELAY_DEFAULT;
			irq_en_r <= OCP_IRQ_EN_RST;
			dsg_at_entry_r <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				discharge_switch_ctl_r <= wr_data[OCP_CTRL_DSG_BIT];
				charge_switch_ctl_r <= wr_data[OCP_CTRL_CHG_BIT];
			end else if (exiting && (discharge_switch_ctl_r == dsg_at_entry_r)) begin
				// auto restore keeps the control bit consistent with the pin
				discharge_switch_ctl_r <= 1'b1;
			end
			if (wr_cfg) begin
				oc_threshold_sel_lo_r <= wr_data[OCP_CFG_THR_LO_BIT];
				oc_threshold_sel_hi_r <= wr_data[OCP_CFG_THR_HI_BIT];
			end
			if (wr_delay)
				oc_delay_r <= delay_merge[OCP_CNT_W-1:0];
			if (wr_en)
				irq_en_r <= wr_data[OCP_NUM_EVT-1:0];
			if (entering)
				dsg_at_entry_r <= discharge_switch_ctl_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gate drive
	always_ff @(posedge clk) begin
		if (reset) begin
			discharge_gate_out <= 1'b1;
			charge_gate_load_sense <= 1'b1;
			load_test_current <= 1'b0;
		end else begin
			if (entering)
				discharge_gate_out <= 1'b1;
			else if (exiting)
				discharge_gate_out <= (discharge_switch_ctl_r != dsg_at_entry_r) ? !discharge_switch_ctl_r : 1'b0;
			else if (!in_prot)
				discharge_gate_out <= !discharge_switch_ctl_r;
			// charge gate held from entry until protection ends
			if (!in_prot && !entering)
				charge_gate_load_sense <= !charge_switch_ctl_r;
			load_test_current <= (state_nxt == OCP_ST_LOAD_MON);
		end
	end

	assign regulator_en = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// interrupts: sticky events, set wins over a simultaneous clear
	wire [OCP_NUM_EVT-1:0] evt;

	assign evt[OCP_EVT_DETECT_START] = (state_r == OCP_ST_NORMAL) && (state_nxt == OCP_ST_DETECT);
	assign evt[OCP_EVT_DETECT_CANCEL] = (state_r == OCP_ST_DETECT) && (state_nxt == OCP_ST_NORMAL);
	assign evt[OCP_EVT_PROT_ENTER] = entering;
	assign evt[OCP_EVT_PROT_EXIT] = exiting;

	wire [OCP_NUM_EVT-1:0] clr_bits = wr_clr ? wr_data[OCP_NUM_EVT-1:0] : '0;

	always_ff @(posedge clk) begin
		if (reset)
			irq_stat_r <= '0;
		else
			irq_stat_r <= (irq_stat_r & ~clr_bits) | evt;
	end

	assign irq = |(irq_stat_r & irq_en_r);

	////////////////////////////////////////////////////////////////////////
	// bus read path
	wire [OCP_STAT_W-1:0] status_word = {discharge_switch_ctl_r != dsg_at_entry_r, load_test_current,
		charge_gate_load_sense, discharge_gate_out, in_prot, state_r};
	logic [31:0] rd_word;
	logic rd_known;

	always_comb begin
		rd_known = 1'b1;
		case (s_axi_araddr)
			OCP_ADDR_CTRL: rd_word = {30'h0, charge_switch_ctl_r, discharge_switch_ctl_r};
			OCP_ADDR_CONFIG: rd_word = {30'h0, thr_sel};
			OCP_ADDR_DELAY: rd_word = {8'h00, oc_delay_r};
			OCP_ADDR_STATUS: rd_word = {25'h0, status_word};
			OCP_ADDR_IRQ_STAT: rd_word = {28'h0, irq_stat_r};
			OCP_ADDR_IRQ_CLR: rd_word = 32'h0000_0000;
			OCP_ADDR_IRQ_EN: rd_word = {28'h0, irq_en_r};
			default: begin
				rd_word = 32'h0000_0000;
				rd_known = 1'b0;
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= OCP_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_known ? OCP_RESP_OKAY : OCP_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ==== testbench/ocp_far_model.sv ====
// ocp_far_model: comparator bank and load sense of the pack front end.
// assumes the bench sets the sense level and load state by clock edge.
`timescale 1ns/100ps
module ocp_far_model (
	input wire logic [2:0] oc_level,
	input wire logic load_open,
	output logic [3:0] sense_diff_above,
	output logic load_above_release
);
	// thermometer code: a level of n trips the comparators below n
	assign sense_diff_above = {oc_level > 3'h3, oc_level > 3'h2, oc_level > 3'h1, oc_level > 3'h0};
	// host keeps series gate off
	// with the charge switch off no sneak current is modelled into the sense path
	assign load_above_release = load_open;
endmodule

// ==== testbench/ocp_protect_monitor.sv ====
// ocp_protect_monitor: port-level checks of the protection block.
// assumes the delay setting is at least 8 cycles whenever protection trips.
`timescale 1ns/100ps
module ocp_protect_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [3:0] sense_diff_above,
	input wire logic load_above_release,
	input wire logic discharge_gate_out,
	input wire logic charge_gate_load_sense,
	input wire logic load_test_current,
	input wire logic regulator_en
);
	wire any_above = |sense_diff_above;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_supply_on: assert property (regulator_en)
		else $error("regulator enable low");
	a_test_gate_off: assert property (load_test_current |-> discharge_gate_out)
		else $error("test current with discharge on");
	a_gates_frozen: assert property (load_test_current |=> $stable(discharge_gate_out) && $stable(charge_gate_load_sense))
		else $error("gate moved in protection");
	a_entry_charge: assert property ($rose(load_test_current) |-> $stable(charge_gate_load_sense))
		else $error("charge gate moved at entry");
	// entry from normal needs the comparator high well before the trip
	a_trip_delay: assert property ($rose(load_test_current) && !$past(discharge_gate_out)
		|-> $past(any_above, 4) && $past(any_above, 8))
		else $error("early trip");
	a_test_stop_cause: assert property ($fell(load_test_current) |-> $past(load_above_release, 2))
		else $error("test current stopped without load release");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("no write response");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	c_trip: cover property ($rose(load_test_current));
	c_release: cover property ($fell(load_test_current));
	c_restore: cover property ($fell(discharge_gate_out) && !load_test_current);
endmodule
bind ocp_protect ocp_protect_monitor mon (.clk(clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .sense_diff_above(sense_diff_above), .load_above_release(load_above_release),
	.discharge_gate_out(discharge_gate_out), .charge_gate_load_sense(charge_gate_load_sense),
	.load_test_current(load_test_current), .regulator_en(regulator_en));

// ==== testbench/ocp_protect_tb_top.sv ====
// ocp_protect_tb_top: directed tests of the overcurrent protection block.
// assumes the far-side model and the port monitor are compiled alongside.
`timescale 1ns/100ps
module ocp_protect_tb_top
	import ocp_pkg::*;
;
	logic clk = 0, reset = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, load_open = 0;
	logic awr, wr_, bv, arr, rv, lar, dsg, chg, tc, reg_en, irq;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdat, got;
	logic [1:0] bresp, rresp, resp;
	logic [2:0] lvl = 0;
	logic [3:0] above;
	int mismatches = 0, samples_checked = 0;
	always #2.5 clk = ~clk;
	ocp_far_model far (.oc_level(lvl), .load_open(load_open), .sense_diff_above(above), .load_above_release(lar));
	// short delay keeps the run small
	ocp_protect #(.DELAY_DEFAULT(24'h000014)) dut (.clk(clk), .reset(reset), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
		.sense_diff_above(above), .load_above_release(lar), .discharge_gate_out(dsg), .charge_gate_load_sense(chg),
		.load_test_current(tc), .regulator_en(reg_en), .irq(irq));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// readies are looked at mid-cycle, releases happen at the next rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		tb = 0;
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		br <= 1'b1;
		while (!tb) begin
			@(negedge clk);
			ta = awv && awr;
			tw = wv && wr_;
			tb = bv;
			resp = bresp;
			@(posedge clk);
			if (ta)
				awv <= 1'b0;
			if (tw)
				wv <= 1'b0;
			if (tb)
				br <= 1'b0;
		end
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		tr = 0;
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		while (!tr) begin
			@(negedge clk);
			ta = arv && arr;
			tr = rv;
			got = rdat;
			resp = rresp;
			@(posedge clk);
			if (ta)
				arv <= 1'b0;
			if (tr)
				rr <= 1'b0;
		end
	endtask
	task automatic wait_tc(input logic v);
		int n;
		n = 0;
		@(negedge clk);
		while (tc !== v && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk(32'(v), 32'(tc));
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		@(negedge clk);
		chk(32'h0000000C, 32'({dsg, chg, tc, irq}));
		rd(OCP_ADDR_CTRL);
		chk(32'(OCP_CTRL_RST), got);
		chk(32'(OCP_RESP_OKAY), 32'(resp));
		rd(OCP_ADDR_DELAY);
		chk(32'h00000014, got);
		rd(OCP_ADDR_CONFIG);
		chk(32'(OCP_CFG_RST), got);
		rd(OCP_ADDR_IRQ_EN);
		chk(32'(OCP_IRQ_EN_RST), got);
		rd(8'h1C);
		chk(32'(OCP_RESP_SLVERR), 32'(resp));
		chk(32'h0, got);
		wr(8'h1C, 32'h00000000);
		chk(32'(OCP_RESP_SLVERR), 32'(resp));
		wr(OCP_ADDR_CTRL, 32'h00000003);
		chk(32'(OCP_RESP_OKAY), 32'(resp));
		repeat (2) @(negedge clk);
		chk(32'h0, 32'({dsg, chg}));
		$display("test regs done");
	endtask
	task automatic t_thresh;
		wr(OCP_ADDR_CONFIG, 32'h00000002);
		wr(OCP_ADDR_DELAY, 32'h00000010);
		lvl <= 3'h2;
		repeat (39) @(posedge clk);
		@(negedge clk);
		chk(32'h0, 32'({dsg, tc}));
		@(posedge clk);
		lvl <= 3'h3;
		repeat (8) @(posedge clk);
		lvl <= 3'h0;
		repeat (29) @(posedge clk);
		@(negedge clk);
		chk(32'h0, 32'({dsg, tc}));
		rd(OCP_ADDR_IRQ_STAT);
		chk(32'h00000003, got);
		wr(OCP_ADDR_IRQ_CLR, 32'h0000000F);
		$display("test threshold done");
	endtask
	task automatic t_trip(input logic hc);
		int n;
		wr(OCP_ADDR_IRQ_EN, 32'h00000004);
		lvl <= 3'h3;
		wait_tc(1'b1);
		chk(32'h0000000B, 32'({dsg, chg, irq, reg_en}));
		// host turns both switches off: the charge gate must still hold until exit
		if (hc)
			wr(OCP_ADDR_CTRL, 32'h00000000);
		@(posedge clk);
		load_open <= 1'b1;
		wait_tc(1'b0);
		chk(32'h00000002, 32'({dsg, chg}));
		if (!hc)
			wait_tc(1'b1);
		@(posedge clk);
		lvl <= 3'h0;
		wait_tc(1'b0);
		n = 0;
		got = 32'h4;
		while (got[2] && n < 40) begin
			rd(OCP_ADDR_STATUS);
			n++;
		end
		chk(32'h0, 32'(got[2]));
		repeat (2) @(negedge clk);
		chk(hc ? 32'h00000003 : 32'h00000000, 32'({chg, dsg}));
		if (!hc) begin
			wr(OCP_ADDR_IRQ_EN, 32'h0);
			@(negedge clk);
			chk(32'h0, 32'(irq));
			wr(OCP_ADDR_IRQ_EN, 32'h00000004);
			@(negedge clk);
			chk(32'h1, 32'(irq));
			wr(OCP_ADDR_IRQ_CLR, 32'h0000000F);
			@(negedge clk);
			chk(32'h0, 32'(irq));
		end
		@(posedge clk);
		load_open <= 1'b0;
		$display("test trip done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		t_regs;
		t_thresh;
		t_trip(1'b0);
		t_trip(1'b1);
		close_out;
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		close_out;
	end
endmodule
